//--- design/drr_pkg.sv
/*
  drr_pkg: constants, register map and bus state encoding shared by the
  dram refresh request unit and its helper modules.
  assumes a 16-bit register port and a 20-bit physical address space.
*/
package drr_pkg;
  // register indices on the register port (word select)
  localparam logic [1:0] REG_UPPER_BASE = 2'h0;
  localparam logic [1:0] REG_INTERVAL   = 2'h1;
  localparam logic [1:0] REG_CONTROL    = 2'h2;
  localparam logic [1:0] REG_ROW_ADDR   = 2'h3;

  // widths
  localparam int REG_DW  = 16;
  localparam int CNT_W   = 9;
  localparam int BASE_W  = 7;
  localparam int ROW_W   = 12;
  localparam int ADDR_W  = 20;
  localparam int CYC_W   = 3;

  // control and row address register layout
  localparam int CTL_ENABLE_BIT = 15;
  localparam logic [5:0] CTL_RSVD_ZERO = 6'h00;
  localparam logic [2:0] ADDR_RSVD_ZERO = 3'h0;

  // counter values
  localparam logic [CNT_W-1:0] CNT_ZERO     = 9'h000;
  localparam logic [CNT_W-1:0] CNT_RELOAD_AT = 9'h001;
  localparam logic [CNT_W-1:0] CNT_ONE      = 9'h001;

  // refresh address bit 0 is always one
  localparam logic REFRESH_LOW_BIT = 1'b1;

  // refresh bus cycle length in clocks, and its last count
  localparam logic [CYC_W-1:0] REFRESH_CYCLE_CLKS = 3'h4;
  localparam logic [CYC_W-1:0] CYC_ONE            = 3'h1;
  localparam logic [CYC_W-1:0] CYC_ZERO           = 3'h0;

  // row counter feedback taps for a 12-bit maximal sequence
  localparam int TAP_A = 11;
  localparam int TAP_B = 5;
  localparam int TAP_C = 3;
  localparam int TAP_D = 0;

  // bus ownership states, gray along idle-held-reclaim-refresh-idle
  typedef enum logic [1:0] {
    BUS_IDLE    = 2'h0,
    BUS_HELD    = 2'h1,
    BUS_RECLAIM = 2'h3,
    BUS_REFRESH = 2'h2
  } drr_bus_e;
endpackage : drr_pkg

//--- design/drr_pin_sync.sv
/*
  drr_pin_sync: three-stage synchroniser for a pin input with a settled
  level and a one-clock falling-edge pulse.
  assumes the pin is asynchronous to clock.
*/
`timescale 1ns/1ns
module drr_pin_sync (
  input  wire logic clock,
  input  wire logic rst,
  input  wire logic pinIn,
  output logic      level,
  output logic      fall
);
  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic level;
    logic fall;
  } drr_sync_s;

  drr_sync_s st_ff;
  drr_sync_s nxt_st;

  // level moves only once the second and third stages agree
  always_comb begin
    nxt_st       = st_ff;
    nxt_st.s1    = pinIn;
    nxt_st.s2    = st_ff.s1;
    nxt_st.s3    = st_ff.s2;
    nxt_st.fall  = 1'b0;
    if (st_ff.s2 == st_ff.s3) begin
      nxt_st.level = st_ff.s3;
      nxt_st.fall  = st_ff.level & ~st_ff.s3;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign level = st_ff.level;
  assign fall  = st_ff.fall;
endmodule : drr_pin_sync

//--- design/drr_row_lfsr.sv
/*
  drr_row_lfsr: 12-bit row counter stepping through every value once per
  period in a shift-register order, zero included.
  assumes advance is a one-clock pulse from the same clock domain.
*/
`timescale 1ns/1ns
module drr_row_lfsr #(
  parameter int ROW_W = drr_pkg::ROW_W
) (
  input  wire logic             clock,
  input  wire logic             rst,
  input  wire logic             advance,
  output logic [ROW_W-1:0]      rowBits
);
  typedef struct packed {
    logic [ROW_W-1:0] row;
  } drr_lfsr_s;

  drr_lfsr_s st_ff;
  drr_lfsr_s nxt_st;
  logic      feedback;

  // zero detect on the low bits splices the all-zero state into the ring
  always_comb begin
    nxt_st   = st_ff;
    feedback = st_ff.row[drr_pkg::TAP_A] ^ st_ff.row[drr_pkg::TAP_B]
             ^ st_ff.row[drr_pkg::TAP_C] ^ st_ff.row[drr_pkg::TAP_D]
             ^ (st_ff.row[ROW_W-2:0] == '0);
    if (advance) begin
      nxt_st.row = {st_ff.row[ROW_W-2:0], feedback};
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign rowBits = st_ff.row;
endmodule : drr_row_lfsr

//--- design/drr_refresh_unit.sv
/*
  drr_refresh_unit: dram refresh request timer, refresh address source
  and bus ownership arbiter with hold/acknowledge handback.
  assumes a simple register port from the peripheral block (one-clock
  strobes), an external dram controller decoding the refresh cycle from
  the strobe outputs, and an alternate master driving the hold pin.
*/
`timescale 1ns/1ns
module drr_refresh_unit #(
  parameter int CNT_W  = drr_pkg::CNT_W,
  parameter int BASE_W = drr_pkg::BASE_W,
  parameter int ROW_W  = drr_pkg::ROW_W
) (
  input  wire logic                      clock,
  input  wire logic                      rst,
  // register port from the peripheral block
  input  wire logic [1:0]                regSel,
  input  wire logic                      regWr,
  input  wire logic                      regRd,
  input  wire logic [drr_pkg::REG_DW-1:0] regWrData,
  output logic [drr_pkg::REG_DW-1:0]     regRdData,
  output logic                           regRdValid,
  // processor output clock pin, sampled
  input  wire logic                      processorOutputClock,
  // hold handshake with the alternate master
  input  wire logic                      holdReq,
  output logic                           busGrantAck,
  // the core's own bus request and its grant
  input  wire logic                      coreBusReq,
  output logic                           coreBusGrant,
  // refresh bus cycle toward the dram controller
  output logic [drr_pkg::ADDR_W-1:0]     refreshAddr,
  output logic                           refreshCycle,
  output logic                           refreshStrobe_n,
  output logic                           highByteEnable_n,
  output logic                           refreshPending
);
  typedef struct packed {
    drr_pkg::drr_bus_e           busState;
    logic                        enable;
    logic [BASE_W-1:0]           upperBase;
    logic [CNT_W-1:0]            interval;
    logic [CNT_W-1:0]            count;
    logic                        pending;
    logic [drr_pkg::CYC_W-1:0]   cycLeft;
    logic                        grantAck;
    logic                        coreGrant;
    logic [drr_pkg::ADDR_W-1:0]  refAddr;
    logic                        cycleActive;
    logic                        strobeN;
    logic                        bheN;
    logic                        rowAdvance;
    logic [drr_pkg::REG_DW-1:0]  rdData;
    logic                        rdValid;
  } drr_unit_s;

  // reset image: strobes idle high, everything else cleared
  localparam drr_unit_s RESET_ST = '{
    busState:    drr_pkg::BUS_IDLE,
    enable:      1'b0,
    upperBase:   '0,
    interval:    '0,
    count:       '0,
    pending:     1'b0,
    cycLeft:     '0,
    grantAck:    1'b0,
    coreGrant:   1'b0,
    refAddr:     '0,
    cycleActive: 1'b0,
    strobeN:     1'b1,
    bheN:        1'b1,
    rowAdvance:  1'b0,
    rdData:      '0,
    rdValid:     1'b0
  };

  drr_unit_s        st_ff;
  drr_unit_s        nxt_st;
  logic             procFall;
  logic             holdLevel;
  logic [ROW_W-1:0] rowBits;
  logic             newReq;
  logic             startRefresh;
  logic             endRefresh;

  // processor output clock: only its falling edges matter
  drr_pin_sync u_clk_sync (
    .clock (clock),
    .rst   (rst),
    .pinIn (processorOutputClock),
    .level (),
    .fall  (procFall)
  );

  // hold request arrives from another master, asynchronous here
  drr_pin_sync u_hold_sync (
    .clock (clock),
    .rst   (rst),
    .pinIn (holdReq),
    .level (holdLevel),
    .fall  ()
  );

  // row bits 12..1 of the refresh address
  drr_row_lfsr #(
    .ROW_W (ROW_W)
  ) u_row (
    .clock   (clock),
    .rst     (rst),
    .advance (st_ff.rowAdvance),
    .rowBits (rowBits)
  );

  // register writes, interval counter, arbitration and read-back
  always_comb begin
    nxt_st       = st_ff;
    newReq       = 1'b0;
    startRefresh = 1'b0;
    endRefresh   = 1'b0;
    nxt_st.rowAdvance = 1'b0;
    nxt_st.rdValid    = 1'b0;

    // register writes; the row address register and count take none
    if (regWr) begin
      case (regSel)
        drr_pkg::REG_UPPER_BASE: begin
          nxt_st.upperBase = regWrData[BASE_W-1:0];
        end
        drr_pkg::REG_INTERVAL: begin
          nxt_st.interval = regWrData[CNT_W-1:0];
        end
        drr_pkg::REG_CONTROL: begin
          nxt_st.enable = regWrData[drr_pkg::CTL_ENABLE_BIT];
        end
        default: begin
          nxt_st.enable = st_ff.enable;
        end
      endcase
    end

    // counter runs off the processor clock, not off bus activity, so the
    // request spacing does not drift with bus latency
    if (!nxt_st.enable) begin
      nxt_st.count = drr_pkg::CNT_ZERO;
    end else if (procFall) begin
      if (st_ff.count == drr_pkg::CNT_ZERO) begin
        nxt_st.count = st_ff.interval; // first load after enabling
      end else if (st_ff.count == drr_pkg::CNT_RELOAD_AT) begin
        nxt_st.count = st_ff.interval;
        newReq       = 1'b1;
      end else begin
        nxt_st.count = st_ff.count - drr_pkg::CNT_ONE;
      end
    end

    // bus ownership
    case (st_ff.busState)
      drr_pkg::BUS_IDLE: begin
        if (st_ff.pending) begin
          startRefresh = 1'b1;
        end else if (holdLevel) begin
          nxt_st.busState  = drr_pkg::BUS_HELD;
          nxt_st.grantAck  = 1'b1;
          nxt_st.coreGrant = 1'b0;
        end else begin
          nxt_st.coreGrant = coreBusReq;
        end
      end
      drr_pkg::BUS_HELD: begin
        if (st_ff.pending) begin
          nxt_st.busState = drr_pkg::BUS_RECLAIM;
          nxt_st.grantAck = 1'b0;
        end else if (!holdLevel) begin
          nxt_st.busState = drr_pkg::BUS_IDLE;
          nxt_st.grantAck = 1'b0;
        end else begin
          nxt_st.grantAck = 1'b1;
        end
      end
      drr_pkg::BUS_RECLAIM: begin
        // the other master still owns the pins until it lets go
        if (!holdLevel) begin
          startRefresh = 1'b1;
        end
      end
      drr_pkg::BUS_REFRESH: begin
        if (st_ff.cycLeft == drr_pkg::CYC_ZERO) begin
          endRefresh = 1'b1;
        end else begin
          nxt_st.cycLeft = st_ff.cycLeft - drr_pkg::CYC_ONE;
        end
      end
      default: begin
        nxt_st.busState = drr_pkg::BUS_IDLE;
      end
    endcase

    // begin the dummy read; base and row are frozen for the cycle
    if (startRefresh) begin
      nxt_st.busState    = drr_pkg::BUS_REFRESH;
      nxt_st.coreGrant   = 1'b0;
      nxt_st.grantAck    = 1'b0;
      nxt_st.cycleActive = 1'b1;
      nxt_st.strobeN     = 1'b0;
      nxt_st.bheN        = 1'b1;
      nxt_st.cycLeft     = drr_pkg::REFRESH_CYCLE_CLKS - drr_pkg::CYC_ONE;
      // no carry from the row into the base: they are simply concatenated
      nxt_st.refAddr     = {st_ff.upperBase, rowBits, drr_pkg::REFRESH_LOW_BIT};
    end

    // finish the cycle before any handback to a holding master
    if (endRefresh) begin
      nxt_st.cycleActive = 1'b0;
      nxt_st.strobeN     = 1'b1;
      nxt_st.pending     = 1'b0;
      nxt_st.rowAdvance  = 1'b1;
      if (holdLevel) begin
        nxt_st.busState = drr_pkg::BUS_HELD;
        nxt_st.grantAck = 1'b1;
      end else begin
        nxt_st.busState = drr_pkg::BUS_IDLE;
      end
    end

    // a new request replaces an unserviced one; set beats the clear
    if (newReq) begin
      nxt_st.pending = 1'b1;
    end

    // read-back, answered one clock after the strobe
    if (regRd) begin
      nxt_st.rdValid = 1'b1;
      case (regSel)
        drr_pkg::REG_UPPER_BASE: begin
          nxt_st.rdData = drr_pkg::REG_DW'(st_ff.upperBase);
        end
        drr_pkg::REG_INTERVAL: begin
          nxt_st.rdData = drr_pkg::REG_DW'(st_ff.interval);
        end
        drr_pkg::REG_CONTROL: begin
          nxt_st.rdData = {st_ff.enable, drr_pkg::CTL_RSVD_ZERO, st_ff.count};
        end
        drr_pkg::REG_ROW_ADDR: begin
          nxt_st.rdData = {drr_pkg::ADDR_RSVD_ZERO, rowBits, drr_pkg::REFRESH_LOW_BIT};
        end
        default: begin
          nxt_st.rdData = '0;
        end
      endcase
    end
  end

  // single state register for this module; the synchronisers and row counter keep their own
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      st_ff <= RESET_ST;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // every output is a field of the state register
  assign regRdData        = st_ff.rdData;
  assign regRdValid       = st_ff.rdValid;
  assign busGrantAck      = st_ff.grantAck;
  assign coreBusGrant     = st_ff.coreGrant;
  assign refreshAddr      = st_ff.refAddr;
  assign refreshCycle     = st_ff.cycleActive;
  assign refreshStrobe_n  = st_ff.strobeN;
  assign highByteEnable_n = st_ff.bheN;
  assign refreshPending   = st_ff.pending;
endmodule : drr_refresh_unit

//--- test/drr_refresh_unit_monitor.sv
/*
  drr_refresh_unit_monitor: port assertions for the refresh unit.
  assumes it is bound to drr_refresh_unit and sees only its ports.
*/
`timescale 1ns/1ns
module drr_refresh_unit_monitor (
  input wire logic                      clock,
  input wire logic                      rst,
  input wire logic                      regRd,
  input wire logic                      regRdValid,
  input wire logic                      holdReq,
  input wire logic                      busGrantAck,
  input wire logic                      coreBusGrant,
  input wire logic [drr_pkg::ADDR_W-1:0] refreshAddr,
  input wire logic                      refreshCycle,
  input wire logic                      refreshStrobe_n,
  input wire logic                      highByteEnable_n,
  input wire logic                      refreshPending
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  // the hold pin is synchronised, so steadiness is judged over several clocks
  sequence s_hold_steady; holdReq [*4]; endsequence
  sequence s_hold_brief; holdReq [*2]; endsequence
  sequence s_refresh_body; refreshCycle [*4] ##1 !refreshCycle; endsequence
  // acknowledge withdrawn because a refresh wants the bus back
  sequence s_reclaim; (busGrantAck && refreshPending) ##1 !busGrantAck; endsequence
  a_read_answer: assert property (regRd |=> regRdValid)
    else $error("read strobe not answered");
  a_answer_cause: assert property (regRdValid |-> $past(regRd))
    else $error("read valid without a read");
  a_low_bit_one: assert property (refreshCycle |-> refreshAddr[0] && highByteEnable_n)
    else $error("refresh address bit 0 low");
  a_strobe_pair: assert property (refreshStrobe_n == !refreshCycle)
    else $error("strobe and cycle disagree");
  a_cycle_length: assert property ($rose(refreshCycle) |-> s_refresh_body)
    else $error("refresh cycle length wrong");
  a_grant_exclusive: assert property (!(busGrantAck && refreshCycle) && !(coreBusGrant && (busGrantAck || refreshCycle)))
    else $error("two bus owners");
  a_hold_kept: assert property (s_hold_steady ##0 (busGrantAck && !refreshPending) |=> busGrantAck)
    else $error("acknowledge lost under hold");
  a_reclaim_bus: assert property (busGrantAck && refreshPending |=> !busGrantAck)
    else $error("acknowledge kept with refresh pending");
  // from idle a pending refresh may start while a fresh hold is still in the synchroniser
  a_start_released: assert property ($rose(refreshCycle) |-> !$past(busGrantAck))
    else $error("refresh started under hold");
  a_reclaim_wait: assert property (s_reclaim |-> !refreshCycle ##1 !refreshCycle)
    else $error("refresh started before hold released");
  a_regrant_after: assert property (s_hold_brief ##0 $fell(refreshCycle) |-> ##[0:8] busGrantAck)
    else $error("no acknowledge after refresh");
  a_served_request: assert property ($rose(refreshCycle) |-> $past(refreshPending))
    else $error("refresh without request");
endmodule : drr_refresh_unit_monitor

bind drr_refresh_unit drr_refresh_unit_monitor mon (.clock(clock), .rst(rst), .regRd(regRd),
  .regRdValid(regRdValid), .holdReq(holdReq), .busGrantAck(busGrantAck), .coreBusGrant(coreBusGrant),
  .refreshAddr(refreshAddr), .refreshCycle(refreshCycle), .refreshStrobe_n(refreshStrobe_n),
  .highByteEnable_n(highByteEnable_n), .refreshPending(refreshPending));

//--- test/drr_hold_partner.sv
/*
  drr_hold_partner: alternate bus master asking for the bus by hold.
  assumes the unit's clock; relDelay sets how slowly it hands back.
*/
`timescale 1ns/1ns
module drr_hold_partner (
  input  wire logic       clock,
  input  wire logic       rst,
  input  wire logic       want,
  input  wire logic [3:0] relDelay,
  input  wire logic       busGrantAck,
  input  wire logic       refreshCycle,
  output logic            holdReq
);
  logic       granted;
  logic       waitRef;
  logic [3:0] cnt;
  // hold state, moved only on the rising edge
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      holdReq <= 1'h0;
      granted <= 1'h0;
      waitRef <= 1'h0;
      cnt <= 4'h0;
    end else if (waitRef) begin
      waitRef <= !refreshCycle; // asks again only once refresh runs
    end else if (!holdReq) begin
      holdReq <= want;
      granted <= 1'h0;
    end else if (busGrantAck) begin
      granted <= 1'h1;
      holdReq <= want; // lets go by choice only while owning the bus
    end else if (granted) begin
      cnt <= cnt + 4'h1;
      if (cnt == relDelay) begin
        holdReq <= 1'h0;
        waitRef <= 1'h1;
        cnt <= 4'h0;
      end
    end
  end
endmodule : drr_hold_partner

//--- test/drr_refresh_unit_tb.sv
/*
  drr_refresh_unit_tb: self-checking bench for the refresh unit.
  assumes the hold partner and the bound monitor are compiled first.
*/
`timescale 1ns/1ns
module drr_refresh_unit_tb;
  logic        clock, rst, regWr, regRd, procClk, want, coreBusReq;
  logic [1:0]  regSel;
  logic [15:0] regWrData, regRdData, rdv;
  logic [3:0]  relDelay;
  logic        regRdValid, holdReq, busGrantAck, coreBusGrant;
  logic        refreshCycle, refreshStrobe_n, highByteEnable_n, refreshPending;
  logic [19:0] refreshAddr;
  int          n_mismatch = 0, check_count = 0, cyc = 0;
  int          mBase, mIntv, t0, dup;
  int          rowQ[$];
  bit          seen[4096];

  drr_refresh_unit dut (.clock(clock), .rst(rst), .regSel(regSel), .regWr(regWr), .regRd(regRd),
    .regWrData(regWrData), .regRdData(regRdData), .regRdValid(regRdValid),
    .processorOutputClock(procClk), .holdReq(holdReq), .busGrantAck(busGrantAck),
    .coreBusReq(coreBusReq), .coreBusGrant(coreBusGrant), .refreshAddr(refreshAddr),
    .refreshCycle(refreshCycle), .refreshStrobe_n(refreshStrobe_n),
    .highByteEnable_n(highByteEnable_n), .refreshPending(refreshPending));
  drr_hold_partner alt (.clock(clock), .rst(rst), .want(want), .relDelay(relDelay),
    .busGrantAck(busGrantAck), .refreshCycle(refreshCycle), .holdReq(holdReq));

  // system clock
  initial begin
    clock = 1'h0;
    forever #10 clock = ~clock;
  end
  // processor clock falls every eight clocks; core asks for the bus at random
  initial begin
    procClk = 1'h0;
    coreBusReq = 1'h0;
    forever begin
      @(posedge clock);
      #2;
      cyc++;
      procClk = cyc[2];
      coreBusReq = 1'($urandom_range(0, 1));
    end
  end
  // watchdog: the sweep needs about 33000 clocks
  initial begin
    repeat (60000) @(posedge clock);
    n_mismatch++;
    print_verdict();
  end

  task automatic chk(string nm, int e, logic [19:0] g);
    check_count++;
    if (g !== 20'(e)) begin
      n_mismatch++;
      $display("mismatch %s expected %0h seen %0h", nm, e, g);
    end
  endtask : chk
  task automatic step;
    @(posedge clock);
    #2;
  endtask : step
  task automatic wr(logic [1:0] s, logic [15:0] d);
    regSel = s;
    regWrData = d;
    regWr = 1'h1;
    step();
    regWr = 1'h0;
  endtask : wr
  task automatic rd(logic [1:0] s);
    regSel = s;
    regRd = 1'h1;
    step();
    regRd = 1'h0;
    chk("read valid", 1, 20'(regRdValid));
    rdv = regRdData;
    step();
  endtask : rd
  // a refresh start is the rise of the cycle flag, so a running one is passed first
  task automatic wait_ref;
    int i;
    i = 0;
    while (refreshCycle === 1'h1) step();
    while (refreshCycle !== 1'h1 && i < 2000) begin
      step();
      i++;
    end
    chk("refresh seen", 1, 20'(refreshCycle));
  endtask : wait_ref
  task automatic wait_ack;
    int i;
    i = 0;
    while (busGrantAck !== 1'h1 && i < 400) begin
      step();
      i++;
    end
  endtask : wait_ack
  task automatic print_verdict;
    $display("counts: %0d mismatches in %0d checks", n_mismatch, check_count);
    if (n_mismatch == 0 && check_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : print_verdict

  // main sequence
  initial begin
    void'($urandom(32'h37B6080E));
    rst = 1'h1;
    regWr = 1'h0;
    regRd = 1'h0;
    regSel = 2'h0;
    regWrData = 16'h0000;
    want = 1'h0;
    relDelay = 4'h0;
    repeat (5) @(posedge clock);
    #2;
    rst = 1'h0;
    for (int s = 0; s < 4; s++) begin
      rd(2'(s));
      chk("reset value", int'(s == 3), 20'(rdv));
    end
    mBase = $urandom;
    wr(2'h0, 16'(mBase));
    mBase &= 'h7F;
    rd(2'h0);
    chk("upper base", mBase, 20'(rdv));
    wr(2'h3, 16'hFFFF);
    rd(2'h3);
    chk("row address", 1, 20'(rdv));
    wr(2'h2, 16'h7FFF);
    rd(2'h2);
    chk("control", 0, 20'(rdv));
    // two spacings: the gap must follow the programmed interval
    for (int k = 0; k < 2; k++) begin
      mIntv = 3 + $urandom_range(0, 5) + k * 6;
      wr(2'h1, 16'(mIntv));
      rd(2'h1);
      chk("interval", mIntv, 20'(rdv));
      wr(2'h2, 16'h8000);
      wait_ref();
      t0 = cyc;
      chk("core grant in refresh", 0, 20'(coreBusGrant));
      chk("refresh strobe", 0, 20'(refreshStrobe_n));
      chk("high byte enable", 1, 20'(highByteEnable_n));
      repeat (6) step();
      rd(2'h3);
      rowQ.push_back(int'(rdv[12:1]));
      rd(2'h2);
      chk("enable", 1, 20'(rdv[15]));
      chk("count in range", 1, 20'(rdv[8:0] <= mIntv));
      wait_ref();
      chk("spacing", mIntv * 8, 20'(cyc - t0));
      chk("refresh address", (mBase << 13) | (rowQ.pop_front() << 1) | 1, refreshAddr);
      wr(2'h2, 16'h0000);
      rd(2'h2);
      chk("disabled", 0, 20'(rdv));
    end
    // hold hand-over, prompt partner then slow partner
    wr(2'h1, 16'h0028);
    wr(2'h2, 16'h8000);
    for (int k = 0; k < 2; k++) begin
      relDelay = 4'(k * 9);
      want = 1'h1;
      wait_ack();
      chk("grant", 1, 20'(busGrantAck));
      wait_ref();
      wait_ack();
      chk("grant back", 1, 20'(busGrantAck));
      want = 1'h0;
      repeat (8) step();
    end
    // full sweep at the shortest interval: every row once, base untouched
    wr(2'h2, 16'h0000);
    wr(2'h1, 16'h0001);
    wr(2'h2, 16'h8000);
    dup = 0;
    for (int i = 0; i < 4096; i++) begin
      wait_ref();
      if (seen[refreshAddr[12:1]] || refreshAddr[19:13] !== 7'(mBase))
        dup++;
      seen[refreshAddr[12:1]] = 1'h1;
    end
    chk("sweep repeats", 0, 20'(dup));
    print_verdict();
  end
endmodule : drr_refresh_unit_tb
